// ---- ext_irq_pending.sv ----
// External request pending logic with its AXI4-Lite register slave.
`timescale 1ns/100ps
`default_nettype none
module ext_irq_pending #(
    parameter int N      = irq_pend_pkg::N_LINES,
    parameter int ADDR_W = irq_pend_pkg::ADDR_W
) (
    // Clock and reset
    input  wire logic                      i_clk,
    input  wire logic                      i_rst_b,
    // External request pins
    input  wire logic [N-1:0]              i_external_request_pin,
    // Processor acknowledge of an accepted line
    input  wire logic                      i_irq_ack,
    input  wire logic [$clog2(N)-1:0]      i_irq_ack_line,
    // Interrupt request to the processor
    output logic                           o_irq,
    output logic [$clog2(N)-1:0]           o_irq_line,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0]         s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready
);
    localparam int LINEW = $clog2(N);
    localparam int LW    = irq_pend_pkg::LVL_W;
    localparam int CW    = irq_pend_pkg::COND_W;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        irq_pend_pkg::chan_e wr_st;
        logic                aw_have;
        logic                w_have;
        logic [ADDR_W-1:0]   awaddr;
        logic [31:0]         wdata;
        logic [3:0]          wstrb;
        logic                awready;
        logic                wready;
        logic                bvalid;
        logic [1:0]          bresp;
        irq_pend_pkg::chan_e rd_st;
        logic                arready;
        logic                rvalid;
        logic [31:0]         rdata;
        logic [1:0]          rresp;
        logic [N-1:0]        enable;
        logic [N-1:0]        pending;
        logic [2*N-1:0]      sense;
        logic [CW-1:0]       cond;
        logic [N*LW-1:0]     prio;
        logic                irq;
        logic [LINEW-1:0]    irq_line;
    } state_s;

    state_s q;
    state_s d;

    logic [N-1:0] hit;

    irq_arb_if #(.N(N), .LINEW(LINEW)) arb_bus ();

    // ------------------------------------------------------------
    // Sense detection and arbitration
    // ------------------------------------------------------------
    ext_sense_detect #(.N(N)) u_sense (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_pin   (i_external_request_pin),
        .i_sense (q.sense),
        .o_hit   (hit)
    );

    irq_line_arbiter #(.N(N), .LINEW(LINEW)) u_arb (
        .bus (arb_bus.arb)
    );

    assign arb_bus.pending    = q.pending;
    assign arb_bus.enable     = q.enable;
    assign arb_bus.prio       = q.prio;
    assign arb_bus.mask_level = q.cond[irq_pend_pkg::COND_LVL_LSB +: LW];
    assign arb_bus.mask_all   = q.cond[irq_pend_pkg::COND_I_BIT]
                                || q.cond[irq_pend_pkg::COND_USER_BIT];

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        logic [31:0] r;
        r = '0;
        for (int b = 0; b < 4; b++) begin
            r[8*b +: 8] = {8{strb[b]}};
        end
        return r;
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        logic r;
        if (a == irq_pend_pkg::OFF_ENABLE) begin
            r = 1'b1;
        end else if (a == irq_pend_pkg::OFF_PENDING) begin
            r = 1'b1;
        end else if (a == irq_pend_pkg::OFF_SENSE) begin
            r = 1'b1;
        end else if (a == irq_pend_pkg::OFF_COND) begin
            r = 1'b1;
        end else if (a == irq_pend_pkg::OFF_PRIO) begin
            r = 1'b1;
        end else if (a == irq_pend_pkg::OFF_ACTIVE) begin
            r = 1'b1;
        end else begin
            r = 1'b0;
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [N-1:0] pend;
        logic [31:0]  wr_v;
        pend = '0;
        wr_v = '0;
        d    = q;
        pend = q.pending;

        // Write address and data are taken in either order.
        if (s_axi_awvalid && q.awready) begin
            d.aw_have = 1'b1;
            d.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_have = 1'b1;
            d.wdata  = s_axi_wdata;
            d.wstrb  = s_axi_wstrb;
        end

        case (q.wr_st)
            irq_pend_pkg::CH_IDLE: begin
                if (q.aw_have && q.w_have) begin
                    d.aw_have = 1'b0;
                    d.w_have  = 1'b0;
                    d.bvalid  = 1'b1;
                    d.wr_st   = irq_pend_pkg::CH_BUSY;
                    d.bresp   = mapped(q.awaddr) ? irq_pend_pkg::RESP_OKAY
                                                 : irq_pend_pkg::RESP_DECERR;
                    if (q.awaddr == irq_pend_pkg::OFF_ENABLE) begin
                        wr_v     = merge(32'(q.enable), q.wdata, q.wstrb);
                        d.enable = wr_v[N-1:0];
                    end else if (q.awaddr == irq_pend_pkg::OFF_PENDING) begin
                        wr_v = q.wdata & strb_mask(q.wstrb);
                        pend = pend & ~wr_v[N-1:0];
                    end else if (q.awaddr == irq_pend_pkg::OFF_SENSE) begin
                        wr_v    = merge(32'(q.sense), q.wdata, q.wstrb);
                        d.sense = wr_v[2*N-1:0];
                    end else if (q.awaddr == irq_pend_pkg::OFF_COND) begin
                        wr_v   = merge(32'(q.cond), q.wdata, q.wstrb);
                        d.cond = wr_v[CW-1:0];
                    end else if (q.awaddr == irq_pend_pkg::OFF_PRIO) begin
                        wr_v   = merge(32'(q.prio), q.wdata, q.wstrb);
                        d.prio = wr_v[N*LW-1:0];
                    end
                end
            end
            default: begin
                if (s_axi_bready) begin
                    d.bvalid = 1'b0;
                    d.wr_st  = irq_pend_pkg::CH_IDLE;
                end
            end
        endcase
        d.awready = (d.wr_st == irq_pend_pkg::CH_IDLE) && !d.aw_have;
        d.wready  = (d.wr_st == irq_pend_pkg::CH_IDLE) && !d.w_have;

        // Read channel.
        case (q.rd_st)
            irq_pend_pkg::CH_IDLE: begin
                if (s_axi_arvalid && q.arready) begin
                    d.rvalid = 1'b1;
                    d.rd_st  = irq_pend_pkg::CH_BUSY;
                    d.rresp  = irq_pend_pkg::RESP_OKAY;
                    if (s_axi_araddr == irq_pend_pkg::OFF_ENABLE) begin
                        d.rdata = 32'(q.enable);
                    end else if (s_axi_araddr == irq_pend_pkg::OFF_PENDING) begin
                        d.rdata = 32'(q.pending);
                    end else if (s_axi_araddr == irq_pend_pkg::OFF_SENSE) begin
                        d.rdata = 32'(q.sense);
                    end else if (s_axi_araddr == irq_pend_pkg::OFF_COND) begin
                        d.rdata = 32'(q.cond);
                    end else if (s_axi_araddr == irq_pend_pkg::OFF_PRIO) begin
                        d.rdata = 32'(q.prio);
                    end else if (s_axi_araddr == irq_pend_pkg::OFF_ACTIVE) begin
                        d.rdata = {15'h0000, q.irq, 16'(q.irq_line)};
                    end else begin
                        d.rdata = '0;
                        d.rresp = irq_pend_pkg::RESP_DECERR;
                    end
                end
            end
            default: begin
                if (s_axi_rready) begin
                    d.rvalid = 1'b0;
                    d.rd_st  = irq_pend_pkg::CH_IDLE;
                end
            end
        endcase
        d.arready = (d.rd_st == irq_pend_pkg::CH_IDLE);

        // Pending flags: acceptance clears, a new detection wins over any clear.
        if (i_irq_ack) begin
            pend[i_irq_ack_line] = 1'b0;
        end
        d.pending = pend | hit;

        // Registered request to the processor.
        d.irq      = arb_bus.grant_valid;
        d.irq_line = arb_bus.grant_line;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q          <= '0;
            q.wr_st    <= irq_pend_pkg::CH_IDLE;
            q.rd_st    <= irq_pend_pkg::CH_IDLE;
            q.cond     <= irq_pend_pkg::COND_RESET;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_irq         = q.irq;
    assign o_irq_line    = q.irq_line;
    assign s_axi_awready = q.awready;
    assign s_axi_wready  = q.wready;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_arready = q.arready;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;
    assign s_axi_rvalid  = q.rvalid;
endmodule
`default_nettype wire

// ---- irq_pend_pkg.sv ----
// Constants, encodings and register map for the external request pending logic.
//
// How it works
// - The selected sense condition on a request pin sets that line's pending flag.
// - Pending flags set whatever the line's enable bit holds.
// - Enabling a line whose flag is already pending raises its request.
// - Software clears pending flags by a register write.
// - Processor mask bits and mask level never stop a pending flag being set.
// - Releasing the processor mask lets a pending, enabled line be accepted.
// - Clearing an enable drops the request but keeps the pending flag.
// - Accepting a line's interrupt clears its pending flag automatically.
package irq_pend_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int N_LINES  = 8;
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;
    localparam int LVL_W    = 3;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_ENABLE  = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_PENDING = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_SENSE   = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_COND    = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_PRIO    = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_ACTIVE  = 8'h14;

    // ------------------------------------------------------------
    // Sense select encodings, two bits per line
    // ------------------------------------------------------------
    localparam logic [1:0] SENSE_LOW  = 2'h0;
    localparam logic [1:0] SENSE_FALL = 2'h1;
    localparam logic [1:0] SENSE_RISE = 2'h2;
    localparam logic [1:0] SENSE_BOTH = 2'h3;

    // ------------------------------------------------------------
    // Condition code register fields and reset value
    // ------------------------------------------------------------
    localparam int         COND_W        = 8;
    localparam int         COND_I_BIT    = 0;
    localparam int         COND_USER_BIT = 1;
    localparam int         COND_LVL_LSB  = 4;
    localparam logic [7:0] COND_RESET    = 8'h03;

    // ------------------------------------------------------------
    // Other reset values and bus answers
    // ------------------------------------------------------------
    localparam logic       PIN_IDLE    = 1'b1;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        CH_IDLE = 2'b00,
        CH_BUSY = 2'b01
    } chan_e;

endpackage

// ---- irq_arb_if.sv ----
// Interface carrying request state from the controller to the line arbiter.
`timescale 1ns/100ps
`default_nettype none
interface irq_arb_if #(
    parameter int N     = 8,
    parameter int LINEW = 3
);
    logic [N-1:0]                      pending;
    logic [N-1:0]                      enable;
    logic [N*irq_pend_pkg::LVL_W-1:0]  prio;
    logic [irq_pend_pkg::LVL_W-1:0]    mask_level;
    logic                              mask_all;
    logic                              grant_valid;
    logic [LINEW-1:0]                  grant_line;

    modport ctl (output pending, enable, prio, mask_level, mask_all,
                 input  grant_valid, grant_line);
    modport arb (input  pending, enable, prio, mask_level, mask_all,
                 output grant_valid, grant_line);
endinterface
`default_nettype wire

// ---- ext_sense_detect.sv ----
// Per-line sense condition detector for the external request pins.
`timescale 1ns/100ps
`default_nettype none
module ext_sense_detect #(
    parameter int N = 8
) (
    // Clock and reset
    input  wire logic           i_clk,
    input  wire logic           i_rst_b,
    // Pins and selection
    input  wire logic [N-1:0]   i_pin,
    input  wire logic [2*N-1:0] i_sense,
    // Detected conditions
    output logic [N-1:0]        o_hit
);
    typedef struct packed {
        logic [N-1:0] prev;
    } state_s;

    state_s q;
    state_s d;

    always_comb begin
        d      = q;
        d.prev = i_pin;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q.prev <= {N{irq_pend_pkg::PIN_IDLE}};
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Condition per line
    // ------------------------------------------------------------
    for (genvar g = 0; g < N; g++) begin : g_line
        always_comb begin
            case (i_sense[2*g +: 2])
                irq_pend_pkg::SENSE_LOW:  o_hit[g] = !i_pin[g];
                irq_pend_pkg::SENSE_FALL: o_hit[g] = q.prev[g] && !i_pin[g];
                irq_pend_pkg::SENSE_RISE: o_hit[g] = !q.prev[g] && i_pin[g];
                default:                  o_hit[g] = q.prev[g] ^ i_pin[g];
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- irq_line_arbiter.sv ----
// Picks the lowest-numbered line whose request passes enable and processor mask.
`timescale 1ns/100ps
`default_nettype none
module irq_line_arbiter #(
    parameter int N     = 8,
    parameter int LINEW = 3
) (
    // Request state and grant
    irq_arb_if.arb bus
);
    localparam int LW = irq_pend_pkg::LVL_W;

    logic [N-1:0] req;

    // ------------------------------------------------------------
    // Request per line
    // ------------------------------------------------------------
    for (genvar g = 0; g < N; g++) begin : g_req
        assign req[g] = bus.pending[g] && bus.enable[g] && !bus.mask_all
                        && (bus.prio[g*LW +: LW] > bus.mask_level);
    end

    always_comb begin
        bus.grant_valid = 1'b0;
        bus.grant_line  = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                bus.grant_valid = 1'b1;
                bus.grant_line  = LINEW'(i);
            end
        end
    end
endmodule
`default_nettype wire

// ---- ext_irq_pending_monitor.sv ----
// Checker for the bus answers and the request output of the pending logic.
`timescale 1ns/100ps
`default_nettype none
module ext_irq_pending_monitor #(
    parameter int N = 8
) (
    // Clock and reset
    input wire logic                 i_clk,
    input wire logic                 i_rst_b,
    // Pins, acknowledge and request
    input wire logic [N-1:0]         i_external_request_pin,
    input wire logic                 i_irq_ack,
    input wire logic [$clog2(N)-1:0] i_irq_ack_line,
    input wire logic                 o_irq,
    input wire logic [$clog2(N)-1:0] o_irq_line,
    // Bus handshakes
    input wire logic                 s_axi_awvalid,
    input wire logic                 s_axi_awready,
    input wire logic                 s_axi_wvalid,
    input wire logic                 s_axi_wready,
    input wire logic                 s_axi_bvalid,
    input wire logic                 s_axi_bready,
    input wire logic                 s_axi_arvalid,
    input wire logic                 s_axi_arready,
    input wire logic                 s_axi_rvalid,
    input wire logic                 s_axi_rready,
    input wire logic [1:0]           s_axi_rresp,
    input wire logic [31:0]          s_axi_rdata
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    // Acknowledge of the shown line while no pin can raise a new event.
    sequence ack_hit;
        i_irq_ack && o_irq && i_irq_ack_line == o_irq_line
            && (&i_external_request_pin) && $past(&i_external_request_pin);
    endsequence
    sequence pins_quiet;
        &i_external_request_pin;
    endsequence

    AST_ACK_CLEAR: assert property (ack_hit ##1 pins_quiet |=>
        !o_irq || o_irq_line != $past(i_irq_ack_line, 2))
        else $error("acknowledged line still requested");
    AST_IDLE_LINE: assert property (!o_irq |-> o_irq_line == '0)
        else $error("line number shown without request");
    AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer not on time");
    AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer not on time");
    AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer held after handshake");
    AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer held after handshake");
    AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("second write accepted during answer");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read accepted during answer");
    AST_DEC_ZERO: assert property (s_axi_rvalid
        && s_axi_rresp == irq_pend_pkg::RESP_DECERR |-> s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read returned data");
endmodule

bind ext_irq_pending ext_irq_pending_monitor #(.N(N)) mon (
    .i_clk, .i_rst_b, .i_external_request_pin, .i_irq_ack, .i_irq_ack_line,
    .o_irq, .o_irq_line, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rresp, .s_axi_rdata
);
`default_nettype wire

// ---- irq_far_side.sv ----
// Model of the request pins and of the processor core that accepts requests.
`timescale 1ns/100ps
`default_nettype none
module irq_far_side #(
    parameter int N = 8
) (
    // Clock
    input  wire logic                 i_clk,
    // Request from the block
    input  wire logic                 i_irq,
    input  wire logic [$clog2(N)-1:0] i_irq_line,
    // Pins and acknowledge
    output logic [N-1:0]              o_pin,
    output logic                      o_ack,
    output logic [$clog2(N)-1:0]      o_ack_line
);
    initial begin
        o_pin      = '1;
        o_ack      = 1'b0;
        o_ack_line = '0;
    end

    // Drives the chosen pins low for two cycles, then back to idle high.
    task automatic pulse(input logic [N-1:0] m);
        @(posedge i_clk);
        o_pin <= ~m;
        repeat (2) @(posedge i_clk);
        o_pin <= '1;
        repeat (3) @(posedge i_clk);
    endtask

    // Accepts the shown request with a one-cycle acknowledge.
    task automatic accept(output logic got);
        int k;
        for (k = 0; k < 20 && i_irq !== 1'b1; k++) begin
            @(posedge i_clk);
        end
        got = (k < 20);
        @(posedge i_clk);
        o_ack      <= 1'b1;
        o_ack_line <= i_irq_line;
        @(posedge i_clk);
        o_ack      <= 1'b0;
        o_ack_line <= ~o_ack_line;
    endtask
endmodule
`default_nettype wire

// ---- ext_irq_pending_tb.sv ----
// Self-checking bench for the external request pending logic.
`timescale 1ns/100ps
`default_nettype none
module ext_irq_pending_tb;
    localparam int         N  = irq_pend_pkg::N_LINES;
    localparam logic [1:0] OK = irq_pend_pkg::RESP_OKAY;
    localparam logic [1:0] DE = irq_pend_pkg::RESP_DECERR;
    logic          i_clk         = 1'b0;
    logic          i_rst_b       = 1'b0;
    logic [7:0]    s_axi_awaddr  = 8'h00;
    logic          s_axi_awvalid = 1'b0;
    logic [31:0]   s_axi_wdata   = 32'h0000_0000;
    logic [3:0]    s_axi_wstrb   = 4'hF;
    logic          s_axi_wvalid  = 1'b0;
    logic          s_axi_bready  = 1'b0;
    logic [7:0]    s_axi_araddr  = 8'h00;
    logic          s_axi_arvalid = 1'b0;
    logic          s_axi_rready  = 1'b0;
    logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]    s_axi_bresp, s_axi_rresp;
    logic [31:0]   s_axi_rdata;
    logic [N-1:0]  pin;
    logic          ack, irq, acc;
    logic [2:0]    ack_line, irq_line;
    int            n_mismatch    = 0;
    int            check_count   = 0;

    always #5 i_clk = ~i_clk;

    ext_irq_pending #(.N(N), .ADDR_W(8)) DUT (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_external_request_pin(pin),
        .i_irq_ack(ack), .i_irq_ack_line(ack_line), .o_irq(irq), .o_irq_line(irq_line),
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready
    );

    irq_far_side #(.N(N)) far (
        .i_clk(i_clk), .i_irq(irq), .i_irq_line(irq_line),
        .o_pin(pin), .o_ack(ack), .o_ack_line(ack_line)
    );

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic hung(input int k);
        if (k >= 40) begin
            n_mismatch++;
            $display("mismatch at %0t: no bus answer", $time);
            close_out();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge i_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        hung(k);
        ck(32'(s_axi_bresp), 32'(er));
        s_axi_bready <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int k;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge i_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        hung(k);
        ck(s_axi_rdata, e);
        ck(32'(s_axi_rresp), 32'(er));
        s_axi_rready <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic irqck(input logic e, input logic [2:0] l);
        repeat (3) @(posedge i_clk);
        ck(32'(irq), 32'(e));
        ck(32'(irq_line), 32'(l));
    endtask

    initial begin
        repeat (3) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        irqck(1'b0, 3'h0);
        rd(irq_pend_pkg::OFF_ENABLE, 32'h0000_0000, OK);
        rd(irq_pend_pkg::OFF_PENDING, 32'h0000_0000, OK);
        rd(irq_pend_pkg::OFF_COND, 32'h0000_0003, OK);
        rd(8'h18, 32'h0000_0000, DE);
        wr(8'h18, 32'h0000_00FF, DE);
        s_axi_wstrb <= 4'hE;
        wr(irq_pend_pkg::OFF_ENABLE, 32'h0000_00FF, OK);
        s_axi_wstrb <= 4'hF;
        rd(irq_pend_pkg::OFF_ENABLE, 32'h0000_0000, OK);
        wr(irq_pend_pkg::OFF_PRIO, 32'h0024_9249, OK);
        wr(irq_pend_pkg::OFF_SENSE, 32'h0000_55E4, OK);
        far.pulse(8'h0F);
        rd(irq_pend_pkg::OFF_PENDING, 32'h0000_000F, OK);
        irqck(1'b0, 3'h0);
        wr(irq_pend_pkg::OFF_PENDING, 32'h0000_0001, OK);
        rd(irq_pend_pkg::OFF_PENDING, 32'h0000_000E, OK);
        wr(irq_pend_pkg::OFF_COND, 32'h0000_0000, OK);
        irqck(1'b0, 3'h0);
        wr(irq_pend_pkg::OFF_ENABLE, 32'h0000_0004, OK);
        irqck(1'b1, 3'h2);
        wr(irq_pend_pkg::OFF_COND, 32'h0000_0001, OK);
        irqck(1'b0, 3'h0);
        wr(irq_pend_pkg::OFF_COND, 32'h0000_0000, OK);
        irqck(1'b1, 3'h2);
        wr(irq_pend_pkg::OFF_COND, 32'h0000_0010, OK);
        irqck(1'b0, 3'h0);
        wr(irq_pend_pkg::OFF_COND, 32'h0000_0002, OK);
        irqck(1'b0, 3'h0);
        wr(irq_pend_pkg::OFF_COND, 32'h0000_0000, OK);
        wr(irq_pend_pkg::OFF_ENABLE, 32'h0000_0008, OK);
        irqck(1'b1, 3'h3);
        wr(irq_pend_pkg::OFF_ENABLE, 32'h0000_0000, OK);
        irqck(1'b0, 3'h0);
        rd(irq_pend_pkg::OFF_PENDING, 32'h0000_000E, OK);
        wr(irq_pend_pkg::OFF_ENABLE, 32'h0000_000C, OK);
        irqck(1'b1, 3'h2);
        far.accept(acc);
        ck(32'(acc), 32'h0000_0001);
        irqck(1'b1, 3'h3);
        rd(irq_pend_pkg::OFF_PENDING, 32'h0000_000A, OK);
        rd(irq_pend_pkg::OFF_ACTIVE, 32'h0001_0003, OK);
        far.accept(acc);
        ck(32'(acc), 32'h0000_0001);
        irqck(1'b0, 3'h0);
        rd(irq_pend_pkg::OFF_PENDING, 32'h0000_0002, OK);
        close_out();
    end
endmodule
`default_nettype wire
